// file: pkg/stall_resume_pkg.sv
// Constants and types for the stall resume handler
// Functional notes
// - Retry reprocesses stalled transaction, abort select ignored
// - Terminate: zero-fill success or abort per select
// - Termination model flag forces abort on terminate
// - Stall model unsupported or disabled raises illegal error
// - Secure queue: security select picks stream space
// - Non-secure queue with security select set is illegal
// - Non-secure queue never touches secure stalls
// - Match on stream, security and tag together
// - Unmatched or wrong-stream tag is a no-op
// - Secure and non-secure stream spaces stay separate
// - No substream identifier needed for lookup
// - Retried transactions still obey interconnect ordering
// - Matched stall tag returns to the free pool
// - Duplicate or stale matches may act either way
// - Retry resume leads to retry in finite time
// - Retry sees all invalidations since original arrival
// - Terminate resume completes in finite time
// - Terminate honoured regardless of stage-2 stall setting
package stall_resume_pkg;
  localparam int unsigned SLOTS    = 8;
  localparam int unsigned TAG_W    = 16;
  localparam int unsigned SID_W    = 32;
  localparam int unsigned IDX_W    = 3;
  localparam int unsigned ENTRY_W  = SID_W + 1;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_OCCUPIED = 8'h08;
  localparam logic [7:0] OFS_COUNTS   = 8'h0c;

  // Control field positions
  localparam int unsigned CTL_TERM_MODEL   = 0;
  localparam int unsigned CTL_NS_DISABLE   = 1;
  localparam int unsigned CTL_S_DISABLE    = 2;
  localparam int unsigned CTL_STALL_SUPP   = 3;
  localparam int unsigned CTL_CLR_ILLEGAL  = 8;

  localparam logic [31:0] CONTROL_RESET = 32'h0000_0008;
  localparam logic [1:0]  STALL_MODEL_NONE = 2'h1;
  localparam logic [1:0]  STALL_MODEL_OK   = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Outcome codes on the completion port
  localparam logic [1:0] OUT_RETRY = 2'h0;
  localparam logic [1:0] OUT_ZERO  = 2'h1;
  localparam logic [1:0] OUT_ABORT = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOOKUP,
    ST_ACT
  } cmd_state_t;
endpackage

// file: design/slot_table.sv
// Stall tracking slot memory: stream identifier and security per slot
`timescale 1ns/10ps
module slot_table (
  // Clock
  input  wire logic                                       aclk,
  // Write port
  input  wire logic                                       wr_en,
  input  wire logic [stall_resume_pkg::IDX_W-1:0]         wr_idx,
  input  wire logic [stall_resume_pkg::ENTRY_W-1:0]       wr_data,
  // Read port
  input  wire logic [stall_resume_pkg::IDX_W-1:0]         rd_idx,
  output logic      [stall_resume_pkg::ENTRY_W-1:0]       rd_data
);
  logic [stall_resume_pkg::ENTRY_W-1:0] mem [stall_resume_pkg::SLOTS];

  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end
endmodule

// file: design/stall_resume_handler.sv
// Resume command interpreter for stalled client transactions
`timescale 1ns/10ps
module stall_resume_handler (
  // Clock and reset
  input  wire logic                                   aclk,
  input  wire logic                                   aresetn,
  // Register bus
  input  wire logic [7:0]                             s_axi_awaddr,
  input  wire logic                                   s_axi_awvalid,
  output logic                                        s_axi_awready,
  input  wire logic [31:0]                            s_axi_wdata,
  input  wire logic [3:0]                             s_axi_wstrb,
  input  wire logic                                   s_axi_wvalid,
  output logic                                        s_axi_wready,
  output logic [1:0]                                  s_axi_bresp,
  output logic                                        s_axi_bvalid,
  input  wire logic                                   s_axi_bready,
  input  wire logic [7:0]                             s_axi_araddr,
  input  wire logic                                   s_axi_arvalid,
  output logic                                        s_axi_arready,
  output logic [31:0]                                 s_axi_rdata,
  output logic [1:0]                                  s_axi_rresp,
  output logic                                        s_axi_rvalid,
  input  wire logic                                   s_axi_rready,
  // Stall arrival from the translation pipeline
  input  wire logic                                   stall_valid,
  input  wire logic [stall_resume_pkg::SID_W-1:0]     stall_stream_identifier,
  input  wire logic                                   stall_secure,
  output logic                                        stall_ready,
  output logic [stall_resume_pkg::TAG_W-1:0]          stall_tag_out,
  // Resume command from the command queues
  input  wire logic                                   cmd_valid,
  input  wire logic                                   cmd_from_secure_queue,
  input  wire logic [stall_resume_pkg::SID_W-1:0]     cmd_stream_identifier,
  input  wire logic                                   stream_security_select,
  input  wire logic [stall_resume_pkg::TAG_W-1:0]     stall_tag,
  input  wire logic                                   resume_action,
  input  wire logic                                   abort_select,
  output logic                                        cmd_ready,
  output logic                                        illegal_command_error,
  // Completion toward the stalled transaction
  output logic                                        done_valid,
  output logic [stall_resume_pkg::IDX_W-1:0]          done_slot,
  output logic [1:0]                                  done_outcome
);
  typedef struct packed {
    logic                                   awready;
    logic                                   wready;
    logic                                   bvalid;
    logic [1:0]                             bresp;
    logic                                   arready;
    logic                                   rvalid;
    logic [31:0]                            rdata;
    logic [1:0]                             rresp;
    logic                                   aw_got;
    logic                                   w_got;
    logic [7:0]                             awaddr;
    logic [31:0]                            wdata;
    logic [3:0]                             wstrb;
    logic [31:0]                            control;
    logic [stall_resume_pkg::SLOTS-1:0]     busy;
    logic                                   stall_ready;
    logic [stall_resume_pkg::TAG_W-1:0]     tag_out;
    logic                                   cmd_ready;
    logic                                   illegal;
    logic                                   illegal_sticky;
    stall_resume_pkg::cmd_state_t           state;
    logic [stall_resume_pkg::SID_W-1:0]     c_sid;
    logic                                   c_sec;
    logic [stall_resume_pkg::TAG_W-1:0]     c_tag;
    logic                                   c_act;
    logic                                   c_abort;
    logic                                   done_valid;
    logic [stall_resume_pkg::IDX_W-1:0]     done_slot;
    logic [1:0]                             done_outcome;
    logic [15:0]                            retries;
    logic [15:0]                            terms;
  } state_t;

  state_t r;
  state_t next_r;

  // Lowest free slot, one decode per entry
  logic [stall_resume_pkg::SLOTS-1:0] free_onehot;
  logic [stall_resume_pkg::IDX_W-1:0] free_idx;
  logic                               any_free;
  genvar g;
  generate
    for (g = 0; g < stall_resume_pkg::SLOTS; g++) begin : g_free
      if (g == 0) begin : g_first
        assign free_onehot[g] = ~r.busy[g];
      end else begin : g_rest
        assign free_onehot[g] = ~r.busy[g] & (&r.busy[g-1:0]);
      end
    end
  endgenerate

  always_comb begin
    free_idx = '0;
    for (int i = 0; i < stall_resume_pkg::SLOTS; i++) begin
      if (free_onehot[i]) begin
        free_idx = i[stall_resume_pkg::IDX_W-1:0];
      end
    end
  end
  assign any_free = |free_onehot;

  logic [stall_resume_pkg::ENTRY_W-1:0] rd_entry;
  logic                                 tbl_wr;
  logic [stall_resume_pkg::IDX_W-1:0]   tbl_rd_idx;
  logic                                 stall_take;

  assign stall_take = stall_valid & r.stall_ready;
  assign tbl_wr     = stall_take;
  // Tag encodes the slot index directly
  assign tbl_rd_idx = r.c_tag[stall_resume_pkg::IDX_W-1:0];

  slot_table u_slots (
    .aclk    (aclk),
    .wr_en   (tbl_wr),
    .wr_idx  (free_idx),
    .wr_data ({stall_secure, stall_stream_identifier}),
    .rd_idx  (tbl_rd_idx),
    .rd_data (rd_entry)
  );

  logic [1:0] stall_model;
  logic       q_disabled;
  logic       tag_in_range;
  logic       hit;
  logic       cmd_take;

  assign cmd_take = cmd_valid & r.cmd_ready;
  // Stall model reported per issuing queue's security state
  assign q_disabled  = ~r.control[stall_resume_pkg::CTL_STALL_SUPP] |
                       (cmd_from_secure_queue ? r.control[stall_resume_pkg::CTL_S_DISABLE]
                                              : r.control[stall_resume_pkg::CTL_NS_DISABLE]);
  assign stall_model = q_disabled ? stall_resume_pkg::STALL_MODEL_NONE : stall_resume_pkg::STALL_MODEL_OK;
  assign tag_in_range = (r.c_tag[stall_resume_pkg::TAG_W-1:stall_resume_pkg::IDX_W] == '0);
  // Stream, security and tag must all agree; no substream used
  assign hit = tag_in_range & r.busy[tbl_rd_idx] &
               (rd_entry[stall_resume_pkg::SID_W-1:0] == r.c_sid) &
               (rd_entry[stall_resume_pkg::SID_W] == r.c_sec);

  always_comb begin
    next_r = r;
    next_r.done_valid = 1'b0;
    next_r.illegal    = 1'b0;
    next_r.stall_ready = 1'b0;

    // AXI write path; address and data accepted in either order
    if (s_axi_awvalid & r.awready) begin
      next_r.aw_got  = 1'b1;
      next_r.awaddr  = s_axi_awaddr;
      next_r.awready = 1'b0;
    end
    if (s_axi_wvalid & r.wready) begin
      next_r.w_got  = 1'b1;
      next_r.wdata  = s_axi_wdata;
      next_r.wstrb  = s_axi_wstrb;
      next_r.wready = 1'b0;
    end
    if (r.aw_got & r.w_got & ~r.bvalid) begin
      next_r.bvalid = 1'b1;
      next_r.bresp  = stall_resume_pkg::RESP_OKAY;
      if (r.awaddr == stall_resume_pkg::OFS_CONTROL) begin
        for (int b = 0; b < 4; b++) begin
          if (r.wstrb[b]) begin
            next_r.control[b*8 +: 8] = r.wdata[b*8 +: 8];
          end
        end
        // Clear bit is a strobe, never stored
        next_r.control[stall_resume_pkg::CTL_CLR_ILLEGAL] = 1'b0;
        if (r.wstrb[1] & r.wdata[stall_resume_pkg::CTL_CLR_ILLEGAL]) begin
          next_r.illegal_sticky = 1'b0;
        end
      end else if (r.awaddr != stall_resume_pkg::OFS_STATUS &&
                   r.awaddr != stall_resume_pkg::OFS_OCCUPIED &&
                   r.awaddr != stall_resume_pkg::OFS_COUNTS) begin
        next_r.bresp = stall_resume_pkg::RESP_SLVERR;
      end
    end
    if (r.bvalid & s_axi_bready) begin
      next_r.bvalid  = 1'b0;
      next_r.aw_got  = 1'b0;
      next_r.w_got   = 1'b0;
      next_r.awready = 1'b1;
      next_r.wready  = 1'b1;
    end

    // AXI read path
    if (s_axi_arvalid & r.arready) begin
      next_r.arready = 1'b0;
      next_r.rvalid  = 1'b1;
      next_r.rresp   = stall_resume_pkg::RESP_OKAY;
      case (s_axi_araddr)
        stall_resume_pkg::OFS_CONTROL:  next_r.rdata = r.control;
        stall_resume_pkg::OFS_STATUS:   next_r.rdata = {30'h0, ~any_free, r.illegal_sticky};
        stall_resume_pkg::OFS_OCCUPIED: next_r.rdata = {24'h0, r.busy};
        stall_resume_pkg::OFS_COUNTS:   next_r.rdata = {r.terms, r.retries};
        default: begin
          next_r.rdata = 32'h0;
          next_r.rresp = stall_resume_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (r.rvalid & s_axi_rready) begin
      next_r.rvalid  = 1'b0;
      next_r.arready = 1'b1;
    end

    // Stall capture; one cycle ready pulse keeps handshake simple
    if (stall_take) begin
      next_r.busy[free_idx] = 1'b1;
      next_r.tag_out = {{(stall_resume_pkg::TAG_W-stall_resume_pkg::IDX_W){1'b0}}, free_idx};
    end else if (~r.stall_ready & any_free & stall_valid) begin
      next_r.stall_ready = 1'b1;
    end

    // Command sequencing
    case (r.state)
      stall_resume_pkg::ST_IDLE: begin
        if (cmd_take) begin
          next_r.cmd_ready = 1'b0;
          if (stall_model == stall_resume_pkg::STALL_MODEL_NONE) begin
            next_r.illegal = 1'b1;
            next_r.illegal_sticky = 1'b1;
            next_r.cmd_ready = 1'b1;
          end else if (~cmd_from_secure_queue & stream_security_select) begin
            next_r.illegal = 1'b1;
            next_r.illegal_sticky = 1'b1;
            next_r.cmd_ready = 1'b1;
          end else begin
            next_r.c_sid   = cmd_stream_identifier;
            // Non-secure queue only ever addresses non-secure stalls
            next_r.c_sec   = cmd_from_secure_queue & stream_security_select;
            next_r.c_tag   = stall_tag;
            next_r.c_act   = resume_action;
            next_r.c_abort = abort_select;
            next_r.state   = stall_resume_pkg::ST_LOOKUP;
          end
        end
      end
      stall_resume_pkg::ST_LOOKUP: begin
        next_r.state = stall_resume_pkg::ST_ACT;
      end
      stall_resume_pkg::ST_ACT: begin
        next_r.state = stall_resume_pkg::ST_IDLE;
        next_r.cmd_ready = 1'b1;
        // A miss is a silent no-op
        if (hit) begin
          next_r.done_valid = 1'b1;
          next_r.done_slot  = tbl_rd_idx;
          // Slot freed at once; tag reusable
          next_r.busy[tbl_rd_idx] = 1'b0;
          if (r.c_act) begin
            // Pipeline re-runs lookup from scratch on retry
            next_r.done_outcome = stall_resume_pkg::OUT_RETRY;
            next_r.retries = r.retries + 16'h1;
          end else begin
            // Stage-2 stall setting plays no part here
            next_r.done_outcome = (r.c_abort | r.control[stall_resume_pkg::CTL_TERM_MODEL])
                                  ? stall_resume_pkg::OUT_ABORT : stall_resume_pkg::OUT_ZERO;
            next_r.terms = r.terms + 16'h1;
          end
        end
      end
      default: begin
        next_r.state = stall_resume_pkg::ST_IDLE;
      end
    endcase
    // Same-cycle stall capture wins over release of its slot
    if (stall_take) begin
      next_r.busy[free_idx] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.awready <= 1'b1;
      r.wready  <= 1'b1;
      r.arready <= 1'b1;
      r.cmd_ready <= 1'b1;
      r.control <= stall_resume_pkg::CONTROL_RESET;
      r.state   <= stall_resume_pkg::ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready  = r.wready;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;
  assign stall_ready   = r.stall_ready;
  assign stall_tag_out = r.tag_out;
  assign cmd_ready     = r.cmd_ready;
  assign illegal_command_error = r.illegal;
  assign done_valid    = r.done_valid;
  assign done_slot     = r.done_slot;
  assign done_outcome  = r.done_outcome;

  // Checks
  ns_illegal_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd_take && r.state == stall_resume_pkg::ST_IDLE && !cmd_from_secure_queue && stream_security_select)
    |=> illegal_command_error) else $error("ns queue secure select not flagged");
  model_illegal_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd_take && r.state == stall_resume_pkg::ST_IDLE && q_disabled) |=> illegal_command_error)
    else $error("disabled stall model not flagged");
  cmd_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state == stall_resume_pkg::ST_LOOKUP) |-> ##2 cmd_ready) else $error("command not finished");
  retry_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state == stall_resume_pkg::ST_ACT && hit && r.c_act) |=>
    (done_valid && done_outcome == stall_resume_pkg::OUT_RETRY)) else $error("retry outcome wrong");
  term_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state == stall_resume_pkg::ST_ACT && hit && !r.c_act && !r.c_abort &&
     !r.control[stall_resume_pkg::CTL_TERM_MODEL]) |=> (done_outcome == stall_resume_pkg::OUT_ZERO))
    else $error("zero completion wrong");
  term_model_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state == stall_resume_pkg::ST_ACT && hit && !r.c_act && r.control[stall_resume_pkg::CTL_TERM_MODEL])
    |=> (done_outcome == stall_resume_pkg::OUT_ABORT)) else $error("term model not forcing abort");
  miss_noop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state == stall_resume_pkg::ST_ACT && !hit) |=> !done_valid) else $error("miss affected a slot");
  tag_free_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.state == stall_resume_pkg::ST_ACT && hit && !(stall_take && free_idx == tbl_rd_idx))
    |=> !r.busy[$past(tbl_rd_idx)]) else $error("tag not released");
  // Refused commands leave the old security bit behind, so only a lookup counts
  ns_secure_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd_take && r.state == stall_resume_pkg::ST_IDLE && !cmd_from_secure_queue)
    |=> (r.state != stall_resume_pkg::ST_LOOKUP || !r.c_sec))
    else $error("ns command reached secure space");
  cov_retry_c: cover property (@(posedge aclk) done_valid && done_outcome == stall_resume_pkg::OUT_RETRY);
  cov_abort_c: cover property (@(posedge aclk) done_valid && done_outcome == stall_resume_pkg::OUT_ABORT);
  cov_zero_c:  cover property (@(posedge aclk) done_valid && done_outcome == stall_resume_pkg::OUT_ZERO);
  cov_ill_c:   cover property (@(posedge aclk) illegal_command_error);
endmodule

// file: tb/stall_source.sv
// Behavioural stall source standing in for the translation pipeline
`timescale 1ns/10ps
module stall_source (
  // Clock
  input  wire logic                               aclk,
  // Stall handshake
  input  wire logic                               stall_ready,
  output logic                                    stall_valid,
  output logic [stall_resume_pkg::SID_W-1:0]      stall_stream_identifier,
  output logic                                    stall_secure
);
  initial begin
    stall_valid = 1'b0;
    stall_stream_identifier = '0;
    stall_secure = 1'b0;
  end

  // Held until the taking edge; afterwards scrambled so stale values never match
  task automatic offer(input logic [stall_resume_pkg::SID_W-1:0] sid, input logic sec);
    @(posedge aclk);
    stall_valid <= 1'b1;
    stall_stream_identifier <= sid;
    stall_secure <= sec;
    do @(posedge aclk); while (stall_ready !== 1'b1);
    stall_valid <= 1'b0;
    stall_stream_identifier <= ~sid;
    stall_secure <= ~sec;
  endtask
endmodule

// file: tb/test_stall_resume_handler.sv
// Self-checking bench for the stall resume handler
`timescale 1ns/10ps
module test_stall_resume_handler;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, stall_valid;
  logic        stall_secure, stall_ready, cmd_valid, cmd_from_secure_queue;
  logic        stream_security_select, resume_action, abort_select;
  logic        cmd_ready, illegal_command_error, done_valid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, stall_stream_identifier;
  logic [31:0] cmd_stream_identifier, a_sid, b_sid;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, done_outcome;
  logic [15:0] stall_tag_out, stall_tag, t0, t1, t2;
  logic [2:0]  done_slot;
  logic [33:0] rq[$];
  logic [5:0]  dq[$];
  logic [15:0] tq[$];
  logic [1:0]  bq[$];
  logic        tag_pend;
  int          n_fail, checks, cyc;
  integer      seed;

  stall_resume_handler u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stall_valid,
    .stall_stream_identifier, .stall_secure, .stall_ready, .stall_tag_out,
    .cmd_valid, .cmd_from_secure_queue, .cmd_stream_identifier,
    .stream_security_select, .stall_tag, .resume_action, .abort_select,
    .cmd_ready, .illegal_command_error, .done_valid, .done_slot, .done_outcome
  );

  stall_source u_src (.aclk, .stall_ready, .stall_valid, .stall_stream_identifier, .stall_secure);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [33:0] e, input logic [33:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [6:0] hit(input logic [15:0] t, input logic [1:0] o);
    return {2'b10, t[2:0], o};
  endfunction

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = stall_resume_pkg::RESP_OKAY);
    bq.push_back(e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  // Flags f: secure queue, select, action, abort; x[6] marks an expected answer
  task automatic cmd(input logic [3:0] f, input logic [31:0] sid, input logic [15:0] tg, input logic [6:0] x);
    if (x[6]) dq.push_back(x[5:0]);
    @(posedge aclk);
    {cmd_from_secure_queue, stream_security_select, resume_action, abort_select} <= f;
    cmd_stream_identifier <= sid;
    stall_tag <= tg;
    cmd_valid <= 1'b1;
    do @(posedge aclk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    cmd_stream_identifier <= ~sid;
    stall_tag <= ~tg;
    repeat (4) @(posedge aclk);
  endtask

  // Expected tag is the lowest free slot
  task automatic stl(input logic [31:0] sid, input logic sec, input logic [15:0] e, output logic [15:0] tg);
    tq.push_back(e);
    u_src.offer(sid, sec);
    @(posedge aclk);
    tg = stall_tag_out;
  endtask

  // Results are matched in arrival order against the oldest note
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    // Tag is valid the cycle after the taking edge
    tag_pend <= (aresetn === 1'b1 && stall_valid === 1'b1 && stall_ready === 1'b1);
    if (aresetn === 1'b1 && s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      cmp("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (aresetn === 1'b1 && s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      cmp("write", 34'(bq.pop_front()), 34'(s_axi_bresp));
    if (tag_pend === 1'b1)
      cmp("tag", 34'(tq.pop_front()), 34'(stall_tag_out));
    if (aresetn === 1'b1 && (done_valid === 1'b1 || illegal_command_error === 1'b1))
      cmp("cmd", dq.pop_front(), illegal_command_error ? 6'h20 : {1'b0, done_slot, done_outcome});
    if (cyc > 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    seed = 32'h59473b20;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {cmd_valid, cmd_from_secure_queue, stream_security_select, resume_action, abort_select} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cmd_stream_identifier, stall_tag} = '0;
    s_axi_wstrb = 4'hf;
    n_fail = 0;
    tag_pend = 1'b0;
    checks = 0;
    cyc = 0;
    a_sid = $random(seed);
    b_sid = a_sid ^ 32'h1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axr(8'h00, {2'h0, stall_resume_pkg::CONTROL_RESET});
    axr(8'h40, {stall_resume_pkg::RESP_SLVERR, 32'h0});
    axw(8'h40, 32'h1, stall_resume_pkg::RESP_SLVERR);
    $display("test reset done");
    stl(a_sid, 1'b0, 16'h0, t0);
    stl(a_sid, 1'b1, 16'h1, t1);
    stl(b_sid, 1'b0, 16'h2, t2);
    cmd(4'b0100, a_sid, t0, 7'h60);
    cmd(4'b0000, a_sid, t1, 7'h00);
    cmd(4'b0000, b_sid, t0, 7'h00);
    cmd(4'b1111, a_sid, t1, hit(t1, stall_resume_pkg::OUT_RETRY));
    cmd(4'b0000, a_sid, t0, hit(t0, stall_resume_pkg::OUT_ZERO));
    cmd(4'b1001, b_sid, t2, hit(t2, stall_resume_pkg::OUT_ABORT));
    axr(8'h08, 34'h0);
    axr(8'h0c, 34'h2_0001);
    $display("test lookup done");
    axw(8'h00, 32'h9);
    stl(b_sid, 1'b0, 16'h0, t0);
    cmd(4'b0000, b_sid, t0, hit(t0, stall_resume_pkg::OUT_ABORT));
    axw(8'h00, 32'ha);
    stl(a_sid, 1'b0, 16'h0, t1);
    cmd(4'b0010, a_sid, t1, 7'h60);
    axr(8'h04, 34'h1);
    axw(8'h00, 32'h0);
    cmd(4'b1110, a_sid, t1, 7'h60);
    axw(8'h00, 32'h108);
    cmd(4'b0010, a_sid, t1, hit(t1, stall_resume_pkg::OUT_RETRY));
    axr(8'h04, 34'h0);
    axr(8'h08, 34'h0);
    repeat (10) @(posedge aclk);
    cmp("queues", 34'h0, 34'(rq.size() + dq.size() + tq.size() + bq.size()));
    $display("test modes done");
    report_and_stop();
  end
endmodule
